// ===== src/cmec_pkg.sv
/*
  Package for the CAN mode and error-state controller: register offsets,
  field positions, reset values, mode encodings and thresholds.
  Assumes a 32-bit APB slave with one aligned word per register.
*/
package cmec_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CMEC_ADDR_CTRL = 8'h00;
  localparam logic [7:0] CMEC_ADDR_STAT = 8'h04;
  localparam logic [7:0] CMEC_ADDR_ERRCNT = 8'h08;
  localparam logic [7:0] CMEC_ADDR_EVENT = 8'h0C;
  localparam logic [7:0] CMEC_ADDR_TSTAMP = 8'h10;
  localparam logic [7:0] CMEC_ADDR_MASKINV = 8'h14;
  localparam logic [7:0] CMEC_ADDR_PROTECT = 8'h18;
  localparam logic [7:0] CMEC_ADDR_RXDATA = 8'h1C;

  // ---------------------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------------------
  localparam int CMEC_CTRL_MODE_LSB = 0;
  localparam int CMEC_CTRL_MODE_W = 3;
  localparam int CMEC_CTRL_TEST_LSB = 4;
  localparam int CMEC_CTRL_TEST_W = 2;
  localparam int CMEC_CTRL_OVERWRITE = 8;
  localparam int CMEC_CTRL_MBXPRIO = 9;
  localparam int CMEC_CTRL_PORTEN = 10;
  localparam int CMEC_CTRL_STOP = 11;
  localparam logic [31:0] CMEC_CTRL_RESET = 32'h0000_0800;

  // Requested modes.
  localparam logic [2:0] CMEC_REQ_SLEEP = 3'h0;
  localparam logic [2:0] CMEC_REQ_RESET = 3'h1;
  localparam logic [2:0] CMEC_REQ_HALT = 3'h2;
  localparam logic [2:0] CMEC_REQ_OPER = 3'h3;

  // Test settings.
  localparam logic [1:0] CMEC_TEST_NORMAL = 2'h0;
  localparam logic [1:0] CMEC_TEST_LISTEN = 2'h1;
  localparam logic [1:0] CMEC_TEST_EXTLOOP = 2'h2;
  localparam logic [1:0] CMEC_TEST_INTLOOP = 2'h3;

  // Event register bits (write one to clear).
  localparam int CMEC_EV_MSGLOST = 0;
  localparam int CMEC_EV_TSERR = 1;
  localparam int CMEC_EV_BUSOFF = 2;

  // Bus status encoding.
  localparam logic [1:0] CMEC_BUS_ACTIVE = 2'h0;
  localparam logic [1:0] CMEC_BUS_PASSIVE = 2'h1;
  localparam logic [1:0] CMEC_BUS_OFF = 2'h2;

  // ---------------------------------------------------------------------------
  // Thresholds and timing
  // ---------------------------------------------------------------------------
  localparam logic [8:0] CMEC_PASSIVE_LIMIT = 9'h07F;
  localparam logic [8:0] CMEC_BUSOFF_LIMIT = 9'h0FF;
  localparam logic [31:0] CMEC_UNLOCK_KEY = 32'h0000_A502;
  localparam int CMEC_CLK_MHZ = 25;
  localparam int CMEC_TRANS_NS = 200;
  localparam int CMEC_TRANS_CYC = (CMEC_TRANS_NS * CMEC_CLK_MHZ + 999) / 1000;
  localparam logic [15:0] CMEC_TS_RESET = 16'hFFFF;

  typedef enum logic [4:0] {
    CMEC_ST_SLEEP = 5'b00001,
    CMEC_ST_RESET = 5'b00010,
    CMEC_ST_HALT = 5'b00100,
    CMEC_ST_OPER = 5'b01000,
    CMEC_ST_MOVE = 5'b10000
  } cmec_state_t;

endpackage

// ===== src/cmec_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module cmec_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH):0] level
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  logic doWrite;
  logic doRead;

  assign inReady = (count_q != DEPTH[AW:0]) || outReady;
  assign outValid = (count_q != '0);
  assign outData = mem[rdPtr_q];
  assign level = count_q;
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;

  always_ff @(posedge clock) begin
    if (doWrite) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (doWrite) begin
        wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (doRead) begin
        rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
      end
      if (doWrite && !doRead) begin
        count_q <= count_q + 1'b1;
      end else if (doRead && !doWrite) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule

// ===== src/cmec_err_state.sv
/*
  Bus error-state classifier from the transmit and receive error counters.
  Assumes the counters are held by the protocol engine and are synchronous.
*/
`timescale 1ns/1ps
module cmec_err_state (
  input wire logic clock,
  input wire logic srst,
  input wire logic clearBusOff,
  input wire logic [8:0] txErrCnt,
  input wire logic [7:0] rxErrCnt,
  output logic [1:0] busState
);

  logic busOff_q;

  // Bus-off latches once the transmit counter passes its limit.
  always_ff @(posedge clock) begin
    if (srst) begin
      busOff_q <= 1'b0;
    end else if (txErrCnt > cmec_pkg::CMEC_BUSOFF_LIMIT) begin
      busOff_q <= 1'b1;
    end else if (clearBusOff) begin
      busOff_q <= 1'b0;
    end
  end

  always_comb begin
    if (busOff_q) begin
      busState = cmec_pkg::CMEC_BUS_OFF;
    end else if (txErrCnt >= cmec_pkg::CMEC_PASSIVE_LIMIT || {1'b0, rxErrCnt} >= cmec_pkg::CMEC_PASSIVE_LIMIT) begin
      busState = cmec_pkg::CMEC_BUS_PASSIVE;
    end else begin
      busState = cmec_pkg::CMEC_BUS_ACTIVE;
    end
  end

endmodule

// ===== src/cmec_ctrl.sv
/*
  Mode and error-state control of a mailbox CAN controller with APB registers,
  port/transceiver enable, test settings and a receive data FIFO.
  Assumes a synchronous APB master on the same clock and a protocol engine
  that supplies error counters, receive frames and time stamp ticks.
*/
//
// Contract
// - Error-active while both counters below passive.
// - Error-passive once either counter reaches 127.
// - Bus-off when transmit counter exceeds 255.
// - New frame may overwrite unread mailbox.
// - Transmit priority by identifier or mailbox.
// - Per-mailbox mask invalid forces exact match.
// - Sleep left only on request.
// - Halt and reset status show completion.
// - Module-stop halts; unlock needed to clear.
// - Time stamp error when counter hits zero.
// - Flag received message lost or overwritten.
// - Power-up state is sleep.
`timescale 1ns/1ps
module cmec_ctrl #(
  parameter int MBOX = 32,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [8:0] txErrCnt,
  input wire logic [7:0] rxErrCnt,
  input wire logic rxFrameValid,
  input wire logic [31:0] rxFrameData,
  output logic rxFrameReady,
  input wire logic tsTick,
  input wire logic engAckReq,
  input wire logic engErrReq,
  input wire logic engTxBit,
  input wire logic rxPin,
  output logic txPinOut,
  output logic txPinOe,
  output logic xcvrEnable,
  output logic engRxBit,
  output logic engRun,
  output logic prioByMbox,
  output logic [MBOX-1:0] maskInvalid
);

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [2:0] reqMode_q;
  logic [1:0] testSel_q;
  logic overwrite_q;
  logic prioMbox_q;
  logic portEn_q;
  logic stop_q;
  logic unlock_q;
  logic [MBOX-1:0] maskInv_q;
  logic [15:0] tsCount_q;
  logic msgLost_q;
  logic tsErr_q;
  logic busOffEv_q;
  cmec_pkg::cmec_state_t state_q;
  logic [2:0] target_q;
  logic [7:0] moveCnt_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic txPinOut_q;
  logic txPinOe_q;
  logic xcvrEnable_q;
  logic engRxBit_q;
  logic engRun_q;
  logic prioByMbox_q;
  logic [MBOX-1:0] maskInvalidOut_q;
  logic rxFrameReady_q;

  logic [1:0] busState;
  logic wrAccess;
  logic rdAccess;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoPop;
  logic [31:0] fifoOutData;
  logic [$clog2(FIFO_DEPTH):0] fifoLevel;
  logic rxAccept;
  logic rxLose;
  logic loopback;

  // ---------------------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------------------
  assign wrAccess = psel && penable && pwrite && pready_q;
  assign rdAccess = psel && penable && !pwrite && pready_q;
  assign fifoPop = rdAccess && (paddr == cmec_pkg::CMEC_ADDR_RXDATA) && fifoOutValid;

  // One wait state: pready rises in the second access cycle.
  always_ff @(posedge clock) begin
    if (srst) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= psel && penable && !pready_q;
    end
  end

  // Control register, writes blocked while stopped; the stop bit sets freely but clears only after an unlock.
  always_ff @(posedge clock) begin
    if (srst) begin
      reqMode_q <= cmec_pkg::CMEC_REQ_SLEEP;
      testSel_q <= cmec_pkg::CMEC_TEST_NORMAL;
      overwrite_q <= 1'b0;
      prioMbox_q <= 1'b0;
      portEn_q <= 1'b0;
      stop_q <= 1'b1;
    end else if (wrAccess && paddr == cmec_pkg::CMEC_ADDR_CTRL) begin
      if (!stop_q) begin
        reqMode_q <= pwdata[cmec_pkg::CMEC_CTRL_MODE_LSB +: cmec_pkg::CMEC_CTRL_MODE_W];
        testSel_q <= pwdata[cmec_pkg::CMEC_CTRL_TEST_LSB +: cmec_pkg::CMEC_CTRL_TEST_W];
        overwrite_q <= pwdata[cmec_pkg::CMEC_CTRL_OVERWRITE];
        prioMbox_q <= pwdata[cmec_pkg::CMEC_CTRL_MBXPRIO];
        portEn_q <= pwdata[cmec_pkg::CMEC_CTRL_PORTEN];
      end
      if (unlock_q || pwdata[cmec_pkg::CMEC_CTRL_STOP]) begin
        stop_q <= pwdata[cmec_pkg::CMEC_CTRL_STOP];
      end
    end
  end

  // Write-protect unlock: a key write arms one following control write.
  always_ff @(posedge clock) begin
    if (srst) begin
      unlock_q <= 1'b0;
    end else if (wrAccess && paddr == cmec_pkg::CMEC_ADDR_PROTECT) begin
      unlock_q <= (pwdata == cmec_pkg::CMEC_UNLOCK_KEY);
    end else if (wrAccess && paddr == cmec_pkg::CMEC_ADDR_CTRL) begin
      unlock_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      maskInv_q <= '0;
    end else if (wrAccess && paddr == cmec_pkg::CMEC_ADDR_MASKINV && !stop_q) begin
      maskInv_q <= pwdata[MBOX-1:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Mode state machine
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      state_q <= cmec_pkg::CMEC_ST_SLEEP;
      target_q <= cmec_pkg::CMEC_REQ_SLEEP;
      moveCnt_q <= '0;
    end else if (stop_q) begin
      state_q <= state_q;
    end else begin
      unique case (state_q)
        cmec_pkg::CMEC_ST_MOVE: begin
          if (moveCnt_q == 8'(cmec_pkg::CMEC_TRANS_CYC - 1)) begin
            unique case (target_q)
              cmec_pkg::CMEC_REQ_RESET: state_q <= cmec_pkg::CMEC_ST_RESET;
              cmec_pkg::CMEC_REQ_HALT: state_q <= cmec_pkg::CMEC_ST_HALT;
              cmec_pkg::CMEC_REQ_OPER: state_q <= cmec_pkg::CMEC_ST_OPER;
              default: state_q <= cmec_pkg::CMEC_ST_SLEEP;
            endcase
          end else begin
            moveCnt_q <= moveCnt_q + 8'h01;
          end
        end
        cmec_pkg::CMEC_ST_SLEEP, cmec_pkg::CMEC_ST_RESET,
        cmec_pkg::CMEC_ST_HALT, cmec_pkg::CMEC_ST_OPER: begin
          // Sleep is only left when software requests another mode.
          if (reqMode_q != target_q) begin
            target_q <= reqMode_q;
            moveCnt_q <= '0;
            state_q <= cmec_pkg::CMEC_ST_MOVE;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Events: time stamp, lost messages, bus-off
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      tsCount_q <= cmec_pkg::CMEC_TS_RESET;
    end else if (tsTick && state_q == cmec_pkg::CMEC_ST_OPER) begin
      tsCount_q <= tsCount_q - 16'h0001;
    end
  end

  // Frames arrive while the FIFO is full: overwrite mode drops the oldest.
  assign rxAccept = rxFrameValid && (!rxLose || overwrite_q);
  assign rxLose = rxFrameValid && fifoLevel[$clog2(FIFO_DEPTH)];

  always_ff @(posedge clock) begin
    if (srst) begin
      msgLost_q <= 1'b0;
      tsErr_q <= 1'b0;
      busOffEv_q <= 1'b0;
    end else begin
      // Hardware set wins over a same-cycle clear.
      if (rxLose) begin
        msgLost_q <= 1'b1;
      end else if (wrAccess && paddr == cmec_pkg::CMEC_ADDR_EVENT && pwdata[cmec_pkg::CMEC_EV_MSGLOST]) begin
        msgLost_q <= 1'b0;
      end
      if (tsCount_q == 16'h0000) begin
        tsErr_q <= 1'b1;
      end else if (wrAccess && paddr == cmec_pkg::CMEC_ADDR_EVENT && pwdata[cmec_pkg::CMEC_EV_TSERR]) begin
        tsErr_q <= 1'b0;
      end
      if (busState == cmec_pkg::CMEC_BUS_OFF) begin
        busOffEv_q <= 1'b1;
      end else if (wrAccess && paddr == cmec_pkg::CMEC_ADDR_EVENT && pwdata[cmec_pkg::CMEC_EV_BUSOFF]) begin
        busOffEv_q <= 1'b0;
      end
    end
  end

  cmec_err_state u_err (
    .clock(clock),
    .srst(srst),
    .clearBusOff(state_q == cmec_pkg::CMEC_ST_RESET),
    .txErrCnt(txErrCnt),
    .rxErrCnt(rxErrCnt),
    .busState(busState)
  );

  cmec_fifo #(
    .WIDTH(32),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .srst(srst),
    .inValid(rxAccept),
    .inReady(fifoInReady),
    .inData(rxFrameData),
    .outValid(fifoOutValid),
    .outReady(fifoPop || (rxLose && overwrite_q)),
    .outData(fifoOutData),
    .level(fifoLevel)
  );

  // ---------------------------------------------------------------------------
  // Pins and engine controls
  // ---------------------------------------------------------------------------
  assign loopback = (testSel_q == cmec_pkg::CMEC_TEST_INTLOOP);

  always_ff @(posedge clock) begin
    if (srst) begin
      txPinOut_q <= 1'b1;
      txPinOe_q <= 1'b0;
      xcvrEnable_q <= 1'b0;
      engRxBit_q <= 1'b1;
      engRun_q <= 1'b0;
      prioByMbox_q <= 1'b0;
      maskInvalidOut_q <= '0;
      rxFrameReady_q <= 1'b0;
    end else begin
      xcvrEnable_q <= portEn_q && !stop_q;
      txPinOe_q <= portEn_q && !stop_q && !loopback;
      if (testSel_q == cmec_pkg::CMEC_TEST_LISTEN && (engAckReq || engErrReq)) begin
        txPinOut_q <= 1'b1;
      end else begin
        txPinOut_q <= engTxBit;
      end
      engRxBit_q <= loopback ? engTxBit : rxPin;
      engRun_q <= (state_q == cmec_pkg::CMEC_ST_OPER) && !stop_q;
      prioByMbox_q <= prioMbox_q;
      maskInvalidOut_q <= maskInv_q;
      rxFrameReady_q <= fifoInReady || overwrite_q;
    end
  end

  // ---------------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end else if (psel && penable && !pready_q) begin
      pslverr_q <= 1'b0;
      unique case (paddr)
        cmec_pkg::CMEC_ADDR_CTRL: prdata_q <= {20'h00000, stop_q, portEn_q, prioMbox_q, overwrite_q,
                                               2'h0, testSel_q, 1'b0, reqMode_q};
        cmec_pkg::CMEC_ADDR_STAT: prdata_q <= {22'h000000, busState, 3'h0, state_q};
        cmec_pkg::CMEC_ADDR_ERRCNT: prdata_q <= {15'h0000, txErrCnt, rxErrCnt};
        cmec_pkg::CMEC_ADDR_EVENT: prdata_q <= {29'h00000000, busOffEv_q, tsErr_q, msgLost_q};
        cmec_pkg::CMEC_ADDR_TSTAMP: prdata_q <= {16'h0000, tsCount_q};
        cmec_pkg::CMEC_ADDR_MASKINV: prdata_q <= 32'(maskInv_q);
        cmec_pkg::CMEC_ADDR_PROTECT: prdata_q <= {31'h00000000, unlock_q};
        cmec_pkg::CMEC_ADDR_RXDATA: prdata_q <= fifoOutValid ? fifoOutData : 32'h00000000;
        default: begin
          prdata_q <= 32'h00000000;
          pslverr_q <= 1'b1;
        end
      endcase
    end else begin
      pslverr_q <= 1'b0;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign txPinOut = txPinOut_q;
  assign txPinOe = txPinOe_q;
  assign xcvrEnable = xcvrEnable_q;
  assign engRxBit = engRxBit_q;
  assign engRun = engRun_q;
  assign prioByMbox = prioByMbox_q;
  assign maskInvalid = maskInvalidOut_q;
  assign rxFrameReady = rxFrameReady_q;

endmodule

// ===== tb/cmec_ctrl_monitor.sv
/*
  Checker for the CAN mode and error-state controller, bound to its top.
  Assumes the package is compiled first and the APB timing of the hand-over.
*/
`timescale 1ns/1ps
module cmec_ctrl_monitor #(
  parameter int MBOX = 32
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [8:0] txErrCnt,
  input wire logic [7:0] rxErrCnt,
  input wire logic txPinOut,
  input wire logic txPinOe,
  input wire logic xcvrEnable,
  input wire logic engRun,
  input wire logic prioByMbox,
  input wire logic [MBOX-1:0] maskInvalid
);
  // ---------------------------------------------------------------------------
  // Port properties
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  logic statRd;
  logic ctrlRd;
  assign statRd = pready && !pwrite && paddr == cmec_pkg::CMEC_ADDR_STAT;
  assign ctrlRd = pready && !pwrite && paddr == cmec_pkg::CMEC_ADDR_CTRL;

  AST_RESET_IDLE: assert property ($past(srst) |-> !engRun && !xcvrEnable && !txPinOe && txPinOut)
    else $error("outputs not idle after reset");
  AST_ACCESS_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("pready not one cycle after access start");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready held too long");
  AST_UNMAPPED: assert property (pready |-> (pslverr == (paddr > 8'h1C)) && (!pslverr || prdata == 32'h0))
    else $error("slave error does not match the address");
  AST_STAT_CODE: assert property (statRd |-> $onehot(prdata[4:0]) && prdata[9:8] != 2'h3)
    else $error("state code not one-hot");
  AST_ACTIVE: assert property (statRd && prdata[9:8] == cmec_pkg::CMEC_BUS_ACTIVE
    |-> $past(txErrCnt, 4) < cmec_pkg::CMEC_PASSIVE_LIMIT && $past(rxErrCnt, 4) < 8'h7F)
    else $error("active reported with a high counter");
  AST_PASSIVE: assert property (statRd && prdata[9:8] == cmec_pkg::CMEC_BUS_PASSIVE
    |-> $past(txErrCnt, 4) >= cmec_pkg::CMEC_PASSIVE_LIMIT || $past(rxErrCnt, 4) >= 8'h7F)
    else $error("passive reported with low counters");
  AST_BUSOFF: assert property (statRd && $past(txErrCnt, 4) > cmec_pkg::CMEC_BUSOFF_LIMIT
    |-> prdata[9:8] == cmec_pkg::CMEC_BUS_OFF)
    else $error("bus-off not reported");
  AST_STOP_IDLE: assert property (ctrlRd && prdata[cmec_pkg::CMEC_CTRL_STOP] |-> !engRun)
    else $error("engine runs while stopped");
  AST_PRIO_COPY: assert property (ctrlRd |-> prioByMbox == prdata[cmec_pkg::CMEC_CTRL_MBXPRIO])
    else $error("priority output differs from control");
  AST_MASK_COPY: assert property (pready && !pwrite && paddr == cmec_pkg::CMEC_ADDR_MASKINV
    |-> maskInvalid == prdata[MBOX-1:0])
    else $error("mask-invalid output differs from register");
  AST_PORT_OFF: assert property (!xcvrEnable |-> !txPinOe)
    else $error("pin driven with transceiver off");
endmodule

bind cmec_ctrl cmec_ctrl_monitor #(.MBOX(MBOX)) u_mon (.clock(clock), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .txErrCnt(txErrCnt), .rxErrCnt(rxErrCnt), .txPinOut(txPinOut), .txPinOe(txPinOe), .xcvrEnable(xcvrEnable),
  .engRun(engRun), .prioByMbox(prioByMbox), .maskInvalid(maskInvalid));

// ===== tb/cmec_bus_node_model.sv
/*
  Model of the far side: frames arriving from other nodes and the shared bus wire.
  Assumes the bench requests frames and sets the level other nodes drive.
*/
`timescale 1ns/1ps
module cmec_bus_node_model (
  input wire logic clock,
  input wire logic srst,
  input wire logic sendReq,
  input wire logic [31:0] sendData,
  input wire logic nodeBit,
  output logic rxFrameValid,
  output logic [31:0] rxFrameData,
  input wire logic rxFrameReady,
  input wire logic txPinOut,
  input wire logic txPinOe,
  output logic rxPin
);
  logic [1:0] waitCnt_q;

  // The bus is wired-AND and recessive high when nobody drives it.
  assign rxPin = nodeBit & (txPinOe ? txPinOut : 1'b1);

  // Frames on the bus cannot be stalled, so an unaccepted frame is gone after four cycles.
  always_ff @(posedge clock) begin
    if (srst) begin
      rxFrameValid <= 1'b0;
      rxFrameData <= 32'h0;
      waitCnt_q <= 2'h0;
    end else if (rxFrameValid) begin
      waitCnt_q <= waitCnt_q + 2'h1;
      if (rxFrameReady || waitCnt_q == 2'h3) begin
        rxFrameValid <= 1'b0;
        rxFrameData <= ~rxFrameData;
      end
    end else if (sendReq) begin
      rxFrameValid <= 1'b1;
      rxFrameData <= sendData;
      waitCnt_q <= 2'h0;
    end
  end
endmodule

// ===== tb/cmec_ctrl_tb_top.sv
/*
  Self-checking bench for the CAN mode and error-state controller.
  Assumes the package, design, model and checker files are compiled before it.
*/
`timescale 1ns/1ps
module cmec_ctrl_tb_top;
  logic clock, srst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, rxErrCnt;
  logic [8:0] txErrCnt;
  logic [31:0] pwdata, prdata, rxFrameData, sendData, mask, maskInvalid;
  logic rxFrameValid, rxFrameReady, tsTick, engAckReq, engErrReq, engTxBit, rxPin, sendReq, nodeBit;
  logic txPinOut, txPinOe, xcvrEnable, engRxBit, engRun, prioByMbox;
  logic [31:0] frames[9];
  logic [32:0] expQ[$];
  logic [32:0] expV;
  int failures = 0;
  int numChecks = 0;
  logic [8:0] txTab[6] = '{9'h07E, 9'h07F, 9'h000, 9'h0FF, 9'h100, 9'h000};
  logic [7:0] rxTab[6] = '{8'h7E, 8'h00, 8'h7F, 8'h00, 8'h00, 8'h00};
  logic [1:0] busTab[6] = '{2'h0, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2};

  cmec_ctrl dut (.clock(clock), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .txErrCnt(txErrCnt),
    .rxErrCnt(rxErrCnt), .rxFrameValid(rxFrameValid), .rxFrameData(rxFrameData), .rxFrameReady(rxFrameReady),
    .tsTick(tsTick), .engAckReq(engAckReq), .engErrReq(engErrReq), .engTxBit(engTxBit), .rxPin(rxPin),
    .txPinOut(txPinOut), .txPinOe(txPinOe), .xcvrEnable(xcvrEnable), .engRxBit(engRxBit), .engRun(engRun),
    .prioByMbox(prioByMbox), .maskInvalid(maskInvalid));
  cmec_bus_node_model node (.clock(clock), .srst(srst), .sendReq(sendReq), .sendData(sendData),
    .nodeBit(nodeBit), .rxFrameValid(rxFrameValid), .rxFrameData(rxFrameData), .rxFrameReady(rxFrameReady),
    .txPinOut(txPinOut), .txPinOe(txPinOe), .rxPin(rxPin));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // ---------------------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------------------
  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    numChecks++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d failures %0d", numChecks, failures);
    if (failures == 0 && numChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // A read notes its expected {pslverr, prdata}; the monitor below compares it.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] exp);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr) expQ.push_back(exp);
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      give_verdict();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    apb(1'b0, a, 32'h0, {1'b0, d});
  endtask

  function automatic logic [31:0] ctl(input logic [2:0] m, input logic [1:0] t, input logic [31:0] f);
    return {29'h0, m} | {26'h0, t, 4'h0} | f;
  endfunction

  task automatic mode(input logic [2:0] m, input logic [31:0] st);
    wr(cmec_pkg::CMEC_ADDR_CTRL, ctl(m, 2'h0, 32'h0));
    rd(cmec_pkg::CMEC_ADDR_STAT, 32'h10);
    repeat (8) @(posedge clock);
    rd(cmec_pkg::CMEC_ADDR_STAT, st);
  endtask

  always @(posedge clock) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      expV = expQ.size() > 0 ? expQ.pop_front() : 33'h1FFFFFFFF;
      check("read", {pslverr, prdata}, expV);
    end
  end

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, tsTick, engAckReq, engErrReq, engTxBit, sendReq} = 8'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    sendData = 32'h0;
    txErrCnt = 9'h0;
    rxErrCnt = 8'h0;
    nodeBit = 1'b1;
    srst = 1'b1;
    void'($urandom(32'h41BEE15A));
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    rd(cmec_pkg::CMEC_ADDR_CTRL, cmec_pkg::CMEC_CTRL_RESET);
    rd(cmec_pkg::CMEC_ADDR_STAT, 32'h1);
    wr(cmec_pkg::CMEC_ADDR_CTRL, ctl(cmec_pkg::CMEC_REQ_OPER, 2'h0, 32'h800));
    repeat (8) @(posedge clock);
    rd(cmec_pkg::CMEC_ADDR_STAT, 32'h1);
    check("engRun", {32'h0, engRun}, 33'h0);
    wr(cmec_pkg::CMEC_ADDR_PROTECT, cmec_pkg::CMEC_UNLOCK_KEY);
    rd(cmec_pkg::CMEC_ADDR_PROTECT, 32'h1);
    wr(cmec_pkg::CMEC_ADDR_CTRL, 32'h0);
    mode(cmec_pkg::CMEC_REQ_RESET, 32'h2);
    mode(cmec_pkg::CMEC_REQ_HALT, 32'h4);
    mode(cmec_pkg::CMEC_REQ_OPER, 32'h8);
    engAckReq <= 1'b1;
    engTxBit <= 1'b0;
    for (int t = 0; t < 4; t++) begin
      wr(cmec_pkg::CMEC_ADDR_CTRL, ctl(cmec_pkg::CMEC_REQ_OPER, 2'(t), 32'h400));
      repeat (3) @(posedge clock);
      check("xcvr", {32'h0, xcvrEnable}, 33'h1);
      check("oe", {32'h0, txPinOe}, {32'h0, t != 3});
      check("rxbit", {32'h0, engRxBit}, {32'h0, engTxBit | t == 1});
      if (t == 1) check("listen", {32'h0, txPinOut}, 33'h1);
      engErrReq <= t[0];
    end
    wr(cmec_pkg::CMEC_ADDR_CTRL, ctl(cmec_pkg::CMEC_REQ_OPER, 2'h0, 32'h100));
    repeat (3) @(posedge clock);
    check("portoff", {31'h0, xcvrEnable, txPinOe}, 33'h0);
    for (int i = 0; i < 9; i++) begin
      frames[i] = $urandom;
      sendData <= frames[i];
      sendReq <= 1'b1;
      @(posedge clock);
      sendReq <= 1'b0;
      repeat (6) @(posedge clock);
    end
    rd(cmec_pkg::CMEC_ADDR_EVENT, 32'h1);
    for (int i = 0; i < 8; i++) rd(cmec_pkg::CMEC_ADDR_RXDATA, frames[i + 1]);
    rd(cmec_pkg::CMEC_ADDR_RXDATA, 32'h0);
    wr(cmec_pkg::CMEC_ADDR_EVENT, 32'h1);
    rd(cmec_pkg::CMEC_ADDR_EVENT, 32'h0);
    mask = $urandom;
    wr(cmec_pkg::CMEC_ADDR_MASKINV, mask);
    rd(cmec_pkg::CMEC_ADDR_MASKINV, mask);
    wr(cmec_pkg::CMEC_ADDR_CTRL, ctl(cmec_pkg::CMEC_REQ_OPER, 2'h0, 32'h200));
    rd(cmec_pkg::CMEC_ADDR_CTRL, 32'h203);
    apb(1'b0, 8'h20, 32'h0, {1'b1, 32'h0});
    for (int i = 0; i < 6; i++) begin
      txErrCnt <= txTab[i];
      rxErrCnt <= rxTab[i];
      repeat (3) @(posedge clock);
      rd(cmec_pkg::CMEC_ADDR_STAT, {22'h0, busTab[i], 8'h08});
    end
    rd(cmec_pkg::CMEC_ADDR_EVENT, 32'h4);
    wr(cmec_pkg::CMEC_ADDR_CTRL, ctl(cmec_pkg::CMEC_REQ_RESET, 2'h0, 32'h0));
    repeat (8) @(posedge clock);
    rd(cmec_pkg::CMEC_ADDR_STAT, 32'h2);
    wr(cmec_pkg::CMEC_ADDR_EVENT, 32'h4);
    mode(cmec_pkg::CMEC_REQ_OPER, 32'h8);
    rd(cmec_pkg::CMEC_ADDR_TSTAMP, {16'h0, cmec_pkg::CMEC_TS_RESET});
    tsTick <= 1'b1;
    repeat (65535) @(posedge clock);
    tsTick <= 1'b0;
    rd(cmec_pkg::CMEC_ADDR_TSTAMP, 32'h0);
    rd(cmec_pkg::CMEC_ADDR_EVENT, 32'h2);
    repeat (3) @(posedge clock);
    give_verdict();
  end
endmodule
